// File: verilog/hpc_ctrl.sv
`timescale 1ns/1ps
`include "hpc_params.svh"
module hpc_ctrl (
	input  wire logic        sys_clk_i,
	input  wire logic        rst_b_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic [3:0]  wb_sel_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        seek_start_i,
	input  wire logic        preset_i,
	input  wire logic        forward_run_input_i,
	input  wire logic        reverse_run_input_i,
	input  wire logic [5:0]  opdata_sel_i,
	input  wire logic        origin_sensor_i,
	input  wire logic        limit_sensor_pos_i,
	input  wire logic        limit_sensor_neg_i,
	input  wire logic        slot_sensor_input_i,
	input  wire logic        excitation_timing_signal_i,
	input  wire logic        encoder_zero_signal_i,
	input  wire logic        alarm_i,
	input  wire logic        moving_i,
	input  wire logic        step_i,
	output logic             ready_o,
	output logic             origin_found_o,
	output logic             run_o,
	output logic             dir_o,
	output logic      [19:0] speed_o,
	output logic      [19:0] start_speed_o,
	output logic      [19:0] accel_o
);
	hpc_pkg::hpc_state_s s_reg;
	hpc_pkg::hpc_state_s s_next;

	logic              wr;
	logic              rd;
	logic [31:0]       mask;
	logic [31:0]       old_w;
	logic [31:0]       new_w;
	logic              lim_ahead;
	logic              lim_any;
	logic              tim_sig;
	logic              ext_ok;
	logic              qual;
	hpc_pkg::hpc_spd_t vl;
	hpc_pkg::hpc_pos_t off_abs;
	logic              forward_run_input;
	logic              reverse_run_input;

	assign mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
		{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

	always_comb begin
		s_next = s_reg;
		wr = wb_cyc_i & wb_stb_i & wb_we_i & ~s_reg.ack;
		rd = wb_cyc_i & wb_stb_i & ~wb_we_i & ~s_reg.ack;
		forward_run_input = forward_run_input_i;
		reverse_run_input = reverse_run_input_i;
		// encoder zero stands in for excitation timing when chosen
		tim_sig = (s_reg.tim_sel == `HPC_TIM_EXC) ?
			excitation_timing_signal_i :
			(s_reg.tim_sel == `HPC_TIM_ZERO) ?
			encoder_zero_signal_i : 1'b1;
		ext_ok = (~s_reg.slot_sensor_input_en | slot_sensor_input_i) & tim_sig;
		qual = s_reg.slot_sensor_input_en | (s_reg.tim_sel == `HPC_TIM_EXC)
			| (s_reg.tim_sel == `HPC_TIM_ZERO);
		// final approach capped at 500 Hz
		vl = (s_reg.vs < `HPC_VL_MAX) ? s_reg.vs : `HPC_VL_MAX;
		off_abs = s_reg.offset[`HPC_POS_W-1] ?
			hpc_pkg::hpc_pos_t'(-s_reg.offset) : s_reg.offset;
		lim_ahead = s_reg.dir ? limit_sensor_pos_i : limit_sensor_neg_i;
		lim_any = limit_sensor_pos_i | limit_sensor_neg_i;

		// bus: registered ack one cycle after strobe, dropped the cycle after
		s_next.ack = wb_cyc_i & wb_stb_i & ~s_reg.ack;
		unique case (wb_adr_i)
			`HPC_ADR_CFG: old_w = {27'h0, s_reg.start_dir,
				s_reg.tim_sel, s_reg.slot_sensor_input_en, s_reg.mode3};
			`HPC_ADR_BACK: old_w = {17'h0, s_reg.back_steps};
			`HPC_ADR_OFFSET: old_w = {8'h0, s_reg.offset};
			`HPC_ADR_PRESET: old_w = {8'h0, s_reg.preset};
			`HPC_ADR_VS: old_w = {12'h0, s_reg.vs};
			`HPC_ADR_VR: old_w = {12'h0, s_reg.vr};
			`HPC_ADR_ACC: old_w = {12'h0, s_reg.acc};
			`HPC_ADR_STATUS: old_w = {s_reg.st, 18'h0, alarm_i,
				moving_i, s_reg.dir, s_reg.run, s_reg.found,
				s_reg.ready};
			`HPC_ADR_POS: old_w = {8'h0, s_reg.pos};
			default: old_w = 32'h0;
		endcase
		new_w = (old_w & ~mask) | (wb_dat_i & mask);
		s_next.rdata = rd ? old_w : 32'h0;
		if (wr) begin
			unique case (wb_adr_i)
				`HPC_ADR_CFG: begin
					s_next.mode3 = new_w[`HPC_CFG_MODE3];
					s_next.slot_sensor_input_en = new_w[`HPC_CFG_SLOT_SENSOR_INPUT];
					s_next.tim_sel = new_w[`HPC_CFG_TIM_LO+:2];
					s_next.start_dir = new_w[`HPC_CFG_DIR];
				end
				`HPC_ADR_BACK: s_next.back_steps = new_w[14:0];
				`HPC_ADR_OFFSET: s_next.offset = new_w[23:0];
				`HPC_ADR_PRESET: s_next.preset = new_w[23:0];
				`HPC_ADR_VS: s_next.vs = new_w[19:0];
				`HPC_ADR_VR: s_next.vr = new_w[19:0];
				`HPC_ADR_ACC: s_next.acc = new_w[19:0];
				`HPC_ADR_OPD: if (wb_sel_i == 4'hF) begin
					s_next.opd[wb_dat_i[`HPC_OPD_IDX_LO+:6]] =
						wb_dat_i[19:0];
				end
				default: s_next.rdata = s_next.rdata;
			endcase
		end

		// command position follows each step issued, except in a cycle where a preset loads it
		if (step_i) begin
			s_next.pos = s_reg.dir ? s_reg.pos + 24'h000001 :
				s_reg.pos - 24'h000001;
		end

		unique case (s_reg.st)
			hpc_pkg::HPC_IDLE: begin
				if (seek_start_i & s_reg.ready) begin
					s_next.st = hpc_pkg::HPC_SEEK;
					s_next.ready = 1'b0;
					s_next.found = 1'b0;
					s_next.run = 1'b1;
					s_next.dir = s_reg.start_dir;
					s_next.speed = s_reg.vr;
					s_next.start_spd = s_reg.vs;
					s_next.accel = s_reg.acc;
				end else if (preset_i & ~moving_i & ~alarm_i
					& ~s_reg.run) begin
					s_next.pos = s_reg.preset;
					s_next.found = 1'b1;
				end else if (forward_run_input & reverse_run_input) begin
					s_next.run = 1'b0;
				end else if (forward_run_input | reverse_run_input) begin
					// opposite direction waits for standstill
					if (~moving_i | (s_reg.dir == forward_run_input)) begin
						s_next.run = 1'b1;
						s_next.dir = forward_run_input;
						s_next.found = 1'b0;
					end
					s_next.speed = s_reg.opd[opdata_sel_i];
					s_next.start_spd = s_reg.vs;
					s_next.accel = s_reg.acc;
				end else begin
					s_next.run = 1'b0;
				end
			end
			hpc_pkg::HPC_SEEK: begin
				if (s_reg.mode3 & origin_sensor_i) begin
					s_next.st = hpc_pkg::HPC_LEAVE;
					s_next.dir = ~s_reg.dir;
					s_next.speed = vl;
				end else if (lim_ahead) begin
					s_next.dir = ~s_reg.dir;
					if (~s_reg.mode3) begin
						s_next.st = hpc_pkg::HPC_LEAVE;
						s_next.speed = vl;
					end
				end
			end
			hpc_pkg::HPC_LEAVE: begin
				if (s_reg.mode3 & ~origin_sensor_i) begin
					s_next.st = hpc_pkg::HPC_RETURN;
					s_next.dir = ~s_reg.dir;
				end else if (~s_reg.mode3 & ~lim_any) begin
					s_next.st = hpc_pkg::HPC_BACK;
					s_next.cnt = {9'h0, s_reg.back_steps};
				end
			end
			hpc_pkg::HPC_RETURN: begin
				if (origin_sensor_i & ext_ok) begin
					s_next.st = hpc_pkg::HPC_OFFSET;
					s_next.cnt = off_abs;
					// no offset: keep heading, no reversal while coasting
					s_next.dir = (off_abs == 24'h0) ? s_reg.dir :
						~s_reg.offset[`HPC_POS_W-1];
				end
			end
			hpc_pkg::HPC_BACK: begin
				if (s_reg.cnt == 24'h0) begin
					if (qual) begin
						s_next.st = hpc_pkg::HPC_EXT;
					end else begin
						s_next.st = hpc_pkg::HPC_OFFSET;
						s_next.cnt = off_abs;
						s_next.dir = (off_abs == 24'h0) ? s_reg.dir :
							~s_reg.offset[`HPC_POS_W-1];
					end
				end else if (step_i) begin
					s_next.cnt = s_reg.cnt - 24'h000001;
				end
			end
			hpc_pkg::HPC_EXT: begin
				if (ext_ok) begin
					s_next.st = hpc_pkg::HPC_OFFSET;
					s_next.cnt = off_abs;
					s_next.dir = (off_abs == 24'h0) ? s_reg.dir :
						~s_reg.offset[`HPC_POS_W-1];
				end
			end
			hpc_pkg::HPC_OFFSET: begin
				if (s_reg.cnt == 24'h0) begin
					s_next.st = hpc_pkg::HPC_STOP;
					s_next.run = 1'b0;
				end else if (step_i) begin
					s_next.cnt = s_reg.cnt - 24'h000001;
				end
			end
			hpc_pkg::HPC_STOP: begin
				s_next.run = 1'b0;
				if (~moving_i) begin
					s_next.st = hpc_pkg::HPC_IDLE;
					s_next.found = 1'b1;
				end
			end
			default: s_next.st = hpc_pkg::HPC_IDLE;
		endcase

		// ready only when fully at rest and nothing pending
		s_next.ready = (s_next.st == hpc_pkg::HPC_IDLE) & ~s_next.run
			& ~moving_i & ~alarm_i & ~forward_run_input & ~reverse_run_input
			& ~seek_start_i;
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			s_reg <= '0;
			s_reg.st <= hpc_pkg::HPC_IDLE;
			s_reg.start_dir <= `HPC_RST_DIR;
			s_reg.back_steps <= `HPC_RST_BACK;
			s_reg.vs <= `HPC_RST_VS;
			s_reg.vr <= `HPC_RST_VR;
			s_reg.acc <= `HPC_RST_ACC;
			s_reg.opd <= {`HPC_OPD_DEPTH{`HPC_RST_OPD_SPEED}};
		end else begin
			s_reg <= s_next;
		end
	end

	assign wb_dat_o = s_reg.rdata;
	assign wb_ack_o = s_reg.ack;
	assign ready_o = s_reg.ready;
	assign origin_found_o = s_reg.found;
	assign run_o = s_reg.run;
	assign dir_o = s_reg.dir;
	assign speed_o = s_reg.speed;
	assign start_speed_o = s_reg.start_spd;
	assign accel_o = s_reg.accel;
endmodule // hpc_ctrl

// File: verilog/hpc_params.svh
`ifndef HPC_PARAMS_SVH
`define HPC_PARAMS_SVH

`define HPC_ADR_CFG        8'h00
`define HPC_ADR_BACK       8'h04
`define HPC_ADR_OFFSET     8'h08
`define HPC_ADR_PRESET     8'h0C
`define HPC_ADR_VS         8'h10
`define HPC_ADR_VR         8'h14
`define HPC_ADR_ACC        8'h18
`define HPC_ADR_OPD        8'h1C
`define HPC_ADR_STATUS     8'h20
`define HPC_ADR_POS        8'h24

`define HPC_CFG_MODE3      0
`define HPC_CFG_SLOT_SENSOR_INPUT       1
`define HPC_CFG_TIM_LO     2
`define HPC_CFG_DIR        4
`define HPC_OPD_IDX_LO     20

`define HPC_TIM_OFF        2'h0
`define HPC_TIM_EXC        2'h1
`define HPC_TIM_ZERO       2'h2

`define HPC_RST_DIR        1'h1
`define HPC_RST_BACK       15'h00C8
`define HPC_RST_VS         20'h00064
`define HPC_RST_VR         20'h003E8
`define HPC_RST_ACC        20'h07530
`define HPC_RST_OPD_SPEED  20'h003E8
`define HPC_VL_MAX         20'h001F4

`define HPC_SPD_W          20
`define HPC_POS_W          24
`define HPC_OPD_DEPTH      64

`endif

// File: verilog/hpc_pkg.sv
`include "hpc_params.svh"
package hpc_pkg;
	typedef logic [`HPC_SPD_W-1:0] hpc_spd_t;
	typedef logic [`HPC_POS_W-1:0] hpc_pos_t;

	typedef enum logic [7:0] {
		HPC_IDLE   = 8'h01,
		HPC_SEEK   = 8'h02,
		HPC_LEAVE  = 8'h04,
		HPC_RETURN = 8'h08,
		HPC_BACK   = 8'h10,
		HPC_EXT    = 8'h20,
		HPC_OFFSET = 8'h40,
		HPC_STOP   = 8'h80
	} hpc_state_e;

	typedef struct packed {
		hpc_state_e                       st;
		logic                             mode3;
		logic                             slot_sensor_input_en;
		logic [1:0]                       tim_sel;
		logic                             start_dir;
		logic [14:0]                      back_steps;
		hpc_pos_t                         offset;
		hpc_pos_t                         preset;
		hpc_spd_t                         vs;
		hpc_spd_t                         vr;
		hpc_spd_t                         acc;
		logic [`HPC_OPD_DEPTH-1:0][`HPC_SPD_W-1:0] opd;
		hpc_pos_t                         pos;
		hpc_pos_t                         cnt;
		logic                             ready;
		logic                             found;
		logic                             run;
		logic                             dir;
		hpc_spd_t                         speed;
		hpc_spd_t                         start_spd;
		hpc_spd_t                         accel;
		logic                             ack;
		logic [31:0]                      rdata;
	} hpc_state_s;
endpackage

// File: tb/hpc_far_model.sv
`timescale 1ns/1ps
module hpc_far_model (
	input  wire logic sys_clk_i,
	input  wire logic rst_b_i,
	input  wire logic run_o,
	input  wire logic dir_o,
	output logic      moving_i,
	output logic      step_i,
	output logic      limit_sensor_pos_i,
	output logic      limit_sensor_neg_i,
	output logic      origin_sensor_i,
	output int        pos
);
	logic [2:0] mv;
	// coasts four cycles after run drops, one step every other cycle
	always @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			mv <= 3'h0;
			step_i <= 1'h0;
			pos <= 0;
		end else begin
			mv <= run_o ? 3'h4 : (mv != 3'h0 ? mv - 3'h1 : 3'h0);
			step_i <= moving_i && !step_i;
			if (step_i)
				pos <= dir_o ? pos + 1 : pos - 1;
		end
	end
	assign moving_i = mv != 3'h0;
	assign limit_sensor_pos_i = pos >= 20;
	assign limit_sensor_neg_i = pos <= -20;
	// origin sensor active over a short band of positions
	assign origin_sensor_i = pos >= 5 && pos <= 8;
endmodule // hpc_far_model

// File: tb/hpc_chk.sv
`timescale 1ns/1ps
module hpc_chk (
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic seek_start_i,
	input wire logic preset_i,
	input wire logic forward_run_input_i,
	input wire logic reverse_run_input_i,
	input wire logic alarm_i,
	input wire logic moving_i,
	input wire logic ready_o,
	input wire logic origin_found_o,
	input wire logic run_o,
	input wire logic dir_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_b_i);
	sequence s_take;
		seek_start_i && ready_o;
	endsequence
	sequence s_go;
		!ready_o && run_o;
	endsequence
	chk_seek_go: assert property (s_take |=> s_go)
		else $error("seek start not taken");
	chk_run_busy: assert property (run_o |-> !ready_o)
		else $error("ready high while running");
	chk_found_rise: assert property (
		$rose(origin_found_o) |-> !$past(moving_i))
		else $error("found rose while moving");
	chk_preset_take: assert property (
		preset_i && ready_o && !moving_i && !alarm_i |=> origin_found_o)
		else $error("preset not answered");
	chk_both_stop: assert property (
		forward_run_input_i && reverse_run_input_i |=> !run_o)
		else $error("both run inputs still run");
	chk_fwd_run: assert property (forward_run_input_i &&
		!reverse_run_input_i && !moving_i |=> run_o && dir_o)
		else $error("forward run not started");
	chk_rvs_run: assert property (reverse_run_input_i &&
		!forward_run_input_i && !moving_i |=> run_o && !dir_o)
		else $error("reverse run not started");
	chk_ack_next: assert property (
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus ack late");
	chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("bus ack too long");
endmodule // hpc_chk

// File: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
	logic        sys_clk_i, rst_b_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [7:0]  wb_adr_i;
	logic [31:0] wb_dat_i, wb_dat_o, rd;
	logic [3:0]  wb_sel_i;
	logic        seek_start_i, preset_i, forward_run_input_i, step_i;
	logic        reverse_run_input_i, origin_sensor_i, limit_sensor_pos_i;
	logic        limit_sensor_neg_i, slot_sensor_input_i, alarm_i, dir_o;
	logic        excitation_timing_signal_i, encoder_zero_signal_i;
	logic        moving_i, ready_o, origin_found_o, run_o;
	logic [5:0]  opdata_sel_i;
	logic [19:0] speed_o, start_speed_o, accel_o;
	int          pos, miscompares, check_count, cyc_n;

	hpc_ctrl i_hpc_ctrl (.*);
	hpc_far_model i_hpc_far_model (.*);

	task automatic test_done;
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wt(ref logic s, input logic v);
		while (s !== v)
			@(posedge sys_clk_i);
	endtask
	task automatic wb(input logic [7:0] a, input logic w,
		input logic [31:0] d);
		@(posedge sys_clk_i);
		wb_cyc_i <= 1'h1;
		wb_stb_i <= 1'h1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= 4'hF;
		do @(posedge sys_clk_i); while (wb_ack_o !== 1'h1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'h0;
		wb_stb_i <= 1'h0;
	endtask
	task automatic t_regs;
		wb(8'h00, 1'h0, 32'h0);
		chk(rd, 32'h00000010);
		wb(8'h04, 1'h0, 32'h0);
		chk(rd, 32'h000000C8);
		wb(8'h0C, 1'h0, 32'h0);
		chk(rd, 32'h00000000);
		wb(8'hFC, 1'h0, 32'h0);
		chk(rd, 32'h00000000);
		wb(8'h0C, 1'h1, 32'h00800000);
		wb(8'h0C, 1'h0, 32'h0);
		chk({8'h00, rd[23:0]}, 32'h00800000);
		$display("test regs done");
	endtask
	task automatic t_preset;
		@(posedge sys_clk_i);
		alarm_i <= 1'h1;
		preset_i <= 1'h1;
		repeat (4) @(posedge sys_clk_i);
		chk(origin_found_o, 32'h0);
		wb(8'h24, 1'h0, 32'h0);
		chk({8'h00, rd[23:0]}, 32'h00000000);
		alarm_i <= 1'h0;
		wt(origin_found_o, 1'h1);
		preset_i <= 1'h0;
		wb(8'h24, 1'h0, 32'h0);
		chk({8'h00, rd[23:0]}, 32'h00800000);
		$display("test preset done");
	endtask
	task automatic t_cont;
		wb(8'h1C, 1'h1, 32'h00100777);
		@(posedge sys_clk_i);
		forward_run_input_i <= 1'h1;
		repeat (2) @(posedge sys_clk_i);
		chk({run_o, dir_o}, 32'h3);
		chk(speed_o, 32'h003E8);
		opdata_sel_i <= 6'h01;
		repeat (2) @(posedge sys_clk_i);
		chk(speed_o, 32'h00777);
		forward_run_input_i <= 1'h0;
		repeat (2) @(posedge sys_clk_i);
		chk(run_o, 32'h0);
		forward_run_input_i <= 1'h1;
		repeat (2) @(posedge sys_clk_i);
		chk(run_o, 32'h1);
		reverse_run_input_i <= 1'h1;
		repeat (2) @(posedge sys_clk_i);
		chk(run_o, 32'h0);
		forward_run_input_i <= 1'h0;
		wt(moving_i, 1'h0);
		repeat (2) @(posedge sys_clk_i);
		chk({run_o, dir_o}, 32'h2);
		reverse_run_input_i <= 1'h0;
		wt(moving_i, 1'h0);
		$display("test run done");
	endtask
	task automatic t_seek;
		wb(8'h04, 1'h1, 32'h00000005);
		wt(ready_o, 1'h1);
		seek_start_i <= 1'h1;
		wt(ready_o, 1'h0);
		seek_start_i <= 1'h0;
		chk({run_o, dir_o}, 32'h3);
		chk(speed_o, 32'h003E8);
		chk(start_speed_o, 32'h00064);
		chk(accel_o, 32'h07530);
		wt(dir_o, 1'h0);
		@(posedge sys_clk_i);
		chk(speed_o, 32'h00064);
		wt(origin_found_o, 1'h1);
		chk(run_o, 32'h0);
		chk(pos <= 14, 32'h1);
		$display("test seek done");
	endtask
	task automatic t_seek3;
		wb(8'h00, 1'h1, 32'h0000001B);
		wb(8'h00, 1'h0, 32'h0);
		chk(rd, 32'h0000001B);
		slot_sensor_input_i <= 1'h1;
		encoder_zero_signal_i <= 1'h1;
		wt(ready_o, 1'h1);
		seek_start_i <= 1'h1;
		wt(ready_o, 1'h0);
		seek_start_i <= 1'h0;
		wt(origin_found_o, 1'h1);
		chk(run_o, 32'h0);
		chk(pos >= 3 && pos <= 8, 32'h1);
		$display("test seek3 done");
	endtask

	initial begin
		sys_clk_i = 1'h0;
		forever #5 sys_clk_i = ~sys_clk_i;
	end
	always @(posedge sys_clk_i) begin
		cyc_n++;
		if (cyc_n == 20000) begin
			miscompares++;
			test_done();
		end
	end
	initial begin
		{rst_b_i, wb_cyc_i, wb_stb_i, wb_we_i, seek_start_i} = '0;
		{preset_i, forward_run_input_i, reverse_run_input_i} = '0;
		{slot_sensor_input_i, alarm_i} = '0;
		{excitation_timing_signal_i, encoder_zero_signal_i} = '0;
		{wb_adr_i, wb_dat_i, wb_sel_i, opdata_sel_i} = '0;
		repeat (4) @(posedge sys_clk_i);
		rst_b_i <= 1'h1;
		t_regs();
		t_preset();
		t_cont();
		t_seek();
		t_seek3();
		test_done();
	end
endmodule // testbench

bind hpc_ctrl hpc_chk i_hpc_chk (.*);
